// File: include/bssf_pkg.sv
// Shared constants for the bit, shift, skip and flag execution slice
package bssf_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned PC_W = 11;
   localparam int unsigned DADDR_W = 7;
   localparam int unsigned NIB_W = 4;
   localparam int unsigned INSTR_W = 16;

   // ==========================================================
   // Opcodes, compared against the top bits of the instruction word
   localparam logic [7:0] OP_SET_CARRY = 8'h50;    // Word bits 15:8
   localparam logic [11:0] OP_SET_PARAM = 12'h160; // Word bits 15:4
   localparam logic [8:0] OP_SHIFT_LEFT = 9'h098;  // Word bits 15:7
   localparam logic [8:0] OP_SHIFT_RIGHT = 9'h09a;
   localparam logic [8:0] OP_SKIP_BIT0 = 9'h110;
   localparam logic [8:0] OP_SKIP_BIT1 = 9'h111;

   // ==========================================================
   // Parameter flag field
   localparam int unsigned PARAM_WDT_BIT = 3;
   localparam int unsigned WDT_SLOW_DIV = 16384;   // Watchdog input is oscillator / this

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_FLAGS = 12'h004;
   localparam logic [11:0] OFS_PC = 12'h008;
   localparam logic [11:0] OFS_MEM_ADDR = 12'h00c;
   localparam logic [11:0] OFS_MEM_DATA = 12'h010;

   // ==========================================================
   // Field positions
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned FLAGS_CARRY_BIT = 0;
   localparam int unsigned FLAGS_ZERO_BIT = 1;
   localparam int unsigned FLAGS_ACC_LSB = 4;
   localparam int unsigned FLAGS_PARAM_LSB = 8;

   // ==========================================================
   // Values after reset
   localparam logic [PC_W-1:0] PC_RST = 11'h000;
   localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
   localparam logic [NIB_W-1:0] PARAM_RST = 4'h0;
   localparam logic CARRY_RST = 1'b0;
   localparam logic ZERO_RST = 1'b0;
   localparam logic RUN_RST = 1'b0;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bssf_pkg

// File: design/bssf_core.sv
// Execution slice for carry set, parameter flags, zero-fill shifts and bit skips
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - The carry-set opcode forces the carry flag to one in one cycle and changes nothing else but the one-step program counter advance.
// - The parameter-flag load keeps only immediate bit 3, which selects the slow watchdog clock.
// - Left shift moves the nibble up, old bit 3 to carry, zero into bit 0, result to memory and accumulator.
// - Right shift moves the nibble down, old bit 0 to carry, zero into bit 3, result to memory and accumulator.
// - The shifts address their data memory operand with the low seven bits of the word.
// - Skip on bit 0 advances the program counter by two when that bit is one, else by one.
// - Skip on bit 1 advances the program counter by two when that bit is one, else by one, in one cycle.
// - The skips touch only the program counter, never accumulator, flags or memory.
module bssf_core #(
   parameter int unsigned AXI_ADDR_W = 12
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [bssf_pkg::INSTR_W-1:0] instr,
   input wire logic instr_valid,
   output logic [bssf_pkg::PC_W-1:0] pc,
   output logic carry_flag,
   output logic zero_flag,
   output logic [bssf_pkg::NIB_W-1:0] accumulator,
   output logic wdt_slow_clk_sel,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import bssf_pkg::*;

   // ==========================================================
   // Elaboration checks
   generate
      if (AXI_ADDR_W < 5 || AXI_ADDR_W > 12) begin : g_bad_addr_w
         $error("AXI_ADDR_W must lie between 5 and 12");
      end
   endgenerate

   // ==========================================================
   // State
   logic [PC_W-1:0] pc_q, pc_d;
   logic carry_q, carry_d;
   logic zero_q, zero_d;
   logic [NIB_W-1:0] acc_q, acc_d;
   logic [NIB_W-1:0] param_q, param_d;
   logic run_q, run_d;
   logic [DADDR_W-1:0] maddr_q, maddr_d;
   logic awready_q, awready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic wpend_q, wpend_d;
   logic [DADDR_W-1:0] wp_addr_q, wp_addr_d;
   logic [NIB_W-1:0] wp_data_q, wp_data_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;

   // Data memory, no reset: software loads it through the window registers
   logic [NIB_W-1:0] dmem [2**DADDR_W];

   logic exec;
   logic [NIB_W-1:0] opnd;
   logic [NIB_W-1:0] shres;
   logic core_we;
   logic mem_we;
   logic [DADDR_W-1:0] mem_waddr;
   logic [NIB_W-1:0] mem_wdata;
   logic aw_fire;
   logic ar_fire;
   logic [11:0] wofs;
   logic [11:0] rofs;
   logic pc_wr;

   // ==========================================================
   // Bus decode shared by the core and the write channel
   assign aw_fire = awready_q && s_axi_awvalid && s_axi_wvalid;
   assign ar_fire = arready_q && s_axi_arvalid;
   assign wofs = 12'(s_axi_awaddr);
   assign rofs = 12'(s_axi_araddr);
   assign pc_wr = aw_fire && wofs == OFS_PC && (&s_axi_wstrb[1:0]);
   assign exec = instr_valid && run_q;
   assign opnd = dmem[instr[DADDR_W-1:0]];

   // ==========================================================
   // Instruction execution
   always_comb begin
      pc_d = pc_q;
      carry_d = carry_q;
      zero_d = zero_q;
      acc_d = acc_q;
      param_d = param_q;
      core_we = 1'b0;
      shres = opnd;
      // A software load of the counter overrides the step of the same cycle
      if (pc_wr) begin
         pc_d = s_axi_wdata[PC_W-1:0];
      end else if (exec) begin
         pc_d = pc_q + PC_W'(1);
      end
      if (exec) begin
         if (instr[15:8] == OP_SET_CARRY) begin
            carry_d = 1'b1;
         end else if (instr[15:4] == OP_SET_PARAM) begin
            // Low immediate bits are reserved and kept at zero
            param_d = {instr[PARAM_WDT_BIT], 3'h0};
         end else if (instr[15:7] == OP_SHIFT_LEFT) begin
            shres = {opnd[2:0], 1'b0};
            carry_d = opnd[3];
            acc_d = shres;
            zero_d = (shres == 4'h0);
            core_we = 1'b1;
         end else if (instr[15:7] == OP_SHIFT_RIGHT) begin
            shres = {1'b0, opnd[3:1]};
            carry_d = opnd[0];
            acc_d = shres;
            zero_d = (shres == 4'h0);
            core_we = 1'b1;
         end else if (instr[15:7] == OP_SKIP_BIT0) begin
            // Skips leave data state alone and only steer the counter
            if (opnd[0] && !pc_wr) begin
               pc_d = pc_q + PC_W'(2);
            end
         end else if (instr[15:7] == OP_SKIP_BIT1) begin
            if (opnd[1] && !pc_wr) begin
               pc_d = pc_q + PC_W'(2);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_q <= PC_RST;
         carry_q <= CARRY_RST;
         zero_q <= ZERO_RST;
         acc_q <= ACC_RST;
         param_q <= PARAM_RST;
      end else begin
         pc_q <= pc_d;
         carry_q <= carry_d;
         zero_q <= zero_d;
         acc_q <= acc_d;
         param_q <= param_d;
      end
   end

   // ==========================================================
   // Data memory write port; the core has priority over a pending bus write
   always_comb begin
      mem_we = core_we || wpend_q;
      mem_waddr = core_we ? instr[DADDR_W-1:0] : wp_addr_q;
      mem_wdata = core_we ? shres : wp_data_q;
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         dmem[mem_waddr] <= mem_wdata;
      end
   end

   // ==========================================================
   // Write channel: address and data are taken together in one cycle
   always_comb begin
      awready_d = 1'b0;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      run_d = run_q;
      maddr_d = maddr_q;
      wpend_d = wpend_q;
      wp_addr_d = wp_addr_q;
      wp_data_d = wp_data_q;
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // Ready pulses for one cycle only while nothing else is in flight
      if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q && !wpend_q) begin
         awready_d = 1'b1;
      end
      if (aw_fire) begin
         bresp_d = RESP_OKAY;
         bvalid_d = 1'b1;
         case (wofs)
            OFS_CTRL: begin
               if (s_axi_wstrb[0]) begin
                  run_d = s_axi_wdata[CTRL_RUN_BIT];
               end
            end
            OFS_MEM_ADDR: begin
               if (s_axi_wstrb[0]) begin
                  maddr_d = s_axi_wdata[DADDR_W-1:0];
               end
            end
            OFS_MEM_DATA: begin
               // Held until a cycle with no shift result; the answer waits for it
               if (s_axi_wstrb[0]) begin
                  wpend_d = 1'b1;
                  bvalid_d = 1'b0;
                  wp_addr_d = maddr_q;
                  wp_data_d = s_axi_wdata[NIB_W-1:0];
               end
            end
            OFS_PC, OFS_FLAGS: begin
               bresp_d = RESP_OKAY;
            end
            default: begin
               bresp_d = RESP_SLVERR;
            end
         endcase
      end
      if (wpend_q && !core_we) begin
         wpend_d = 1'b0;
         bvalid_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         run_q <= RUN_RST;
         maddr_q <= 7'h00;
         wpend_q <= 1'b0;
         wp_addr_q <= 7'h00;
         wp_data_q <= 4'h0;
      end else begin
         awready_q <= awready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         run_q <= run_d;
         maddr_q <= maddr_d;
         wpend_q <= wpend_d;
         wp_addr_q <= wp_addr_d;
         wp_data_q <= wp_data_d;
      end
   end

   // ==========================================================
   // Read channel: one ready pulse, data answered the next cycle
   always_comb begin
      arready_d = 1'b0;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && !arready_q && !rvalid_q) begin
         arready_d = 1'b1;
      end
      if (ar_fire) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = 32'h0;
         case (rofs)
            OFS_CTRL: begin
               rdata_d[CTRL_RUN_BIT] = run_q;
            end
            OFS_FLAGS: begin
               rdata_d[FLAGS_CARRY_BIT] = carry_q;
               rdata_d[FLAGS_ZERO_BIT] = zero_q;
               rdata_d[FLAGS_ACC_LSB +: NIB_W] = acc_q;
               rdata_d[FLAGS_PARAM_LSB +: NIB_W] = param_q;
            end
            OFS_PC: begin
               rdata_d[PC_W-1:0] = pc_q;
            end
            OFS_MEM_ADDR: begin
               rdata_d[DADDR_W-1:0] = maddr_q;
            end
            OFS_MEM_DATA: begin
               rdata_d[NIB_W-1:0] = dmem[maddr_q];
            end
            default: begin
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign pc = pc_q;
   assign carry_flag = carry_q;
   assign zero_flag = zero_q;
   assign accumulator = acc_q;
   assign wdt_slow_clk_sel = param_q[PARAM_WDT_BIT];
   assign s_axi_awready = awready_q;
   assign s_axi_wready = awready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

endmodule : bssf_core
`default_nettype wire

// File: verif/bssf_core_sva.sv
// Concurrent checks on the ports of the execution slice
`timescale 1ns/1ps
`default_nettype none
module bssf_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [bssf_pkg::INSTR_W-1:0] instr,
   input wire logic instr_valid,
   input wire logic [bssf_pkg::PC_W-1:0] pc,
   input wire logic carry_flag,
   input wire logic zero_flag,
   input wire logic [bssf_pkg::NIB_W-1:0] accumulator,
   input wire logic wdt_slow_clk_sel,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import bssf_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Opcode decode; run is hidden, so a moving pc marks execution
   wire logic sc = instr_valid && instr[15:8] == OP_SET_CARRY;
   wire logic pl = instr_valid && instr[15:4] == OP_SET_PARAM;
   wire logic sl = instr_valid && instr[15:7] == OP_SHIFT_LEFT;
   wire logic sr = instr_valid && instr[15:7] == OP_SHIFT_RIGHT;
   wire logic sk = instr_valid && (instr[15:7] == OP_SKIP_BIT0 || instr[15:7] == OP_SKIP_BIT1);
   // ==========================================================
   // Instruction effects
   a_carry_set: assert property (sc |=> (pc == $past(pc) + 11'h1) |-> carry_flag
      && $stable(accumulator) && $stable(zero_flag) && $stable(wdt_slow_clk_sel))
      else $error("carry set changed the wrong state");
   a_param_load: assert property (pl |=> (pc == $past(pc) + 11'h1) |->
      wdt_slow_clk_sel == $past(instr[3])) else $error("watchdog select mismatch");
   a_left_fill: assert property (sl |=> (pc == $past(pc) + 11'h1) |-> !accumulator[0]
      && zero_flag == (accumulator == 4'h0)) else $error("left shift fill or zero wrong");
   a_right_fill: assert property (sr |=> (pc == $past(pc) + 11'h1) |-> !accumulator[3]
      && zero_flag == (accumulator == 4'h0)) else $error("right shift fill or zero wrong");
   a_skip_step: assert property (sk |=> (pc != $past(pc)) |->
      (pc == $past(pc) + 11'h1 || pc == $past(pc) + 11'h2)) else $error("skip step wrong");
   a_skip_keep: assert property (sk |=> (pc != $past(pc)) |-> $stable(accumulator)
      && $stable(carry_flag) && $stable(zero_flag)) else $error("skip touched state");
   // ==========================================================
   // Bus handshakes
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped early");
   a_accept_pulse: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
      else $error("write accept not a paired pulse");
   c_skip: cover property (sk ##1 pc == $past(pc) + 11'h2);
   c_shift: cover property (sl ##1 carry_flag);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : bssf_chk
bind bssf_core bssf_chk bssf_chk_i (.*);
`default_nettype wire

// File: verif/bssf_pmem.sv
// Program memory model that feeds instruction words at the fetch address
`timescale 1ns/1ps
`default_nettype none
module bssf_pmem (
   input wire logic clk,
   input wire logic en,
   input wire logic [bssf_pkg::PC_W-1:0] pc,
   output logic [bssf_pkg::INSTR_W-1:0] instr,
   output logic instr_valid
);
   import bssf_pkg::*;
   logic [INSTR_W-1:0] rom [2**PC_W];
   logic [INSTR_W-1:0] junk_q = 16'h5aa5;
   // Idle word toggles so a stale opcode never looks like a fetch
   always @(posedge clk) begin
      junk_q <= ~junk_q;
   end
   // Unwritten words are outside this slice and only step the pc
   initial begin
      foreach (rom[i]) rom[i] = '0;
   end
   assign instr_valid = en;
   assign instr = en ? rom[pc] : junk_q;
endmodule : bssf_pmem
`default_nettype wire

// File: verif/bssf_core_tb.sv
// Self-checking testbench for the execution slice
`timescale 1ns/1ps
`default_nettype none
module bssf_core_tb;
   import bssf_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic en = 1'b0;
   logic [INSTR_W-1:0] instr;
   logic instr_valid, carry_flag, zero_flag, wdt_slow_clk_sel;
   logic [PC_W-1:0] pc;
   logic [3:0] accumulator;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   bssf_core bssf_core_i (.*);
   bssf_pmem bssf_pmem_i (.*);
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // Shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Response ready rises with the request and stays up until the answer is sampled;
   // one idle edge at the end keeps the next call from re-driving it in the same step
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_awprot <= a[2:0];
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arprot <= a[2:0];
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
      @(posedge clk);
   endtask : rd
   // Feeds n words back to back, then idles one cycle
   task automatic run(input int n);
      en <= 1'b1;
      repeat (n) @(posedge clk);
      en <= 1'b0;
      @(posedge clk);
   endtask : run
   task automatic st(input logic [10:0] p, input logic c, z, input logic [3:0] a);
      chk(pc, p);
      chk(carry_flag, c);
      chk(zero_flag, z);
      chk(accumulator, a);
   endtask : st
   task automatic ld(input logic [10:0] a, input logic [8:0] op, input logic [6:0] r);
      bssf_pmem_i.rom[a] = {op, r};
   endtask : ld
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rd(OFS_FLAGS, RESP_OKAY);
      chk(d, 32'h0);
      wr(OFS_FLAGS, 32'h3, RESP_OKAY);
      rd(OFS_FLAGS, RESP_OKAY);
      chk(d, 32'h0);
      wr(12'h100, 32'h1, RESP_SLVERR);
      rd(12'h100, RESP_SLVERR);
      chk(d, 32'h0);
      run(2);
      chk(pc, 32'h0);
   endtask : t_regs
   task automatic t_shift;
      wr(OFS_MEM_ADDR, 32'h44, RESP_OKAY);
      wr(OFS_MEM_DATA, 32'h6, RESP_OKAY);
      wr(OFS_MEM_ADDR, 32'h45, RESP_OKAY);
      wr(OFS_MEM_DATA, 32'h9, RESP_OKAY);
      // Carry set is an 8-bit opcode, so it is placed whole rather than through ld
      bssf_pmem_i.rom[0] = {OP_SET_CARRY, 8'h00};
      ld(1, OP_SHIFT_LEFT, 7'h45);
      ld(2, OP_SHIFT_RIGHT, 7'h45);
      ld(3, OP_SHIFT_RIGHT, 7'h45);
      ld(4, OP_SHIFT_LEFT, 7'h45);
      bssf_pmem_i.rom[5] = {OP_SET_CARRY, 8'h00};
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      run(1);
      st(1, 1, 0, 0);
      run(1);
      st(2, 1, 0, 2);
      run(1);
      st(3, 0, 0, 1);
      rd(OFS_MEM_DATA, RESP_OKAY);
      chk(d, 32'h1);
      run(1);
      st(4, 1, 1, 0);
      run(1);
      st(5, 0, 1, 0);
      run(1);
      st(6, 1, 1, 0);
      wr(OFS_MEM_ADDR, 32'h44, RESP_OKAY);
      rd(OFS_MEM_DATA, RESP_OKAY);
      chk(d, 32'h6);
   endtask : t_shift
   task automatic t_param;
      bssf_pmem_i.rom[6] = {OP_SET_PARAM, 4'h8};
      bssf_pmem_i.rom[7] = {OP_SET_PARAM, 4'h7};
      run(1);
      rd(OFS_FLAGS, RESP_OKAY);
      chk(d, 32'h803);
      chk(wdt_slow_clk_sel, 32'h1);
      run(1);
      chk(wdt_slow_clk_sel, 32'h0);
   endtask : t_param
   task automatic t_skip;
      wr(OFS_MEM_ADDR, 32'h10, RESP_OKAY);
      wr(OFS_MEM_DATA, 32'h1, RESP_OKAY);
      wr(OFS_MEM_ADDR, 32'h11, RESP_OKAY);
      wr(OFS_MEM_DATA, 32'h2, RESP_OKAY);
      ld(11'h20, OP_SKIP_BIT0, 7'h10);
      ld(11'h22, OP_SKIP_BIT1, 7'h10);
      ld(11'h23, OP_SKIP_BIT1, 7'h11);
      ld(11'h25, OP_SKIP_BIT0, 7'h11);
      wr(OFS_PC, 32'h20, RESP_OKAY);
      run(4);
      st(11'h26, 1, 1, 0);
      rd(OFS_MEM_DATA, RESP_OKAY);
      chk(d, 32'h2);
   endtask : t_skip
   // ==========================================================
   // Verdict, main sequence and hang guard
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_shift();
      t_param();
      t_skip();
      print_verdict();
   end
   // The whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         print_verdict();
      end
   end
endmodule : bssf_core_tb
`default_nettype wire
